// ==== rtl/sse_params.svh ====
// constants for the shift, store and subtract execution block
`ifndef SSE_PARAMS_SVH
`define SSE_PARAMS_SVH
`define SSE_OP_LSB 0
`define SSE_OP_W 6
`define SSE_OFFSET_LSB 6
`define SSE_OFFSET_W 16
`define SSE_SRC2_LSB 22
`define SSE_SRC1_LSB 27
`define SSE_DEST_LSB 17
`define SSE_OPX_LSB 11
`define SSE_OPX_W 6
`define SSE_SHAMT_LSB 6
`define SSE_SHAMT_W 5
`define SSE_OP_STB 6'h05
`define SSE_OP_STBIO 6'h25
`define SSE_OP_STH 6'h0d
`define SSE_OP_STHIO 6'h2d
`define SSE_OP_STW 6'h15
`define SSE_OP_STWIO 6'h35
`define SSE_OP_RTYPE 6'h3a
`define SSE_OPX_SRLI 6'h1a
`define SSE_OPX_SUB 6'h39
`endif

// ==== rtl/sse_pkg.sv ====
// types shared by the shift, store and subtract execution block
package sse_pkg;
   typedef enum logic [1:0] {
      SSE_SZ_BYTE,
      SSE_SZ_HALF,
      SSE_SZ_WORD
   } sse_size_t;

   typedef struct packed {
      logic valid;
      logic bypass;
      sse_size_t size;
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0] byte_en;
   } sse_store_t;

   typedef struct packed {
      logic valid;
      logic [4:0] dest;
      logic [31:0] value;
   } sse_wb_t;

   typedef struct packed {
      sse_store_t cache_st;
      sse_store_t bus_st;
      sse_wb_t wb;
      logic ovf;
      logic borrow;
      logic illegal;
   } sse_state_t;
endpackage

// ==== rtl/sse_exec.sv ====
// execution unit for logical right shift, stores and subtract
`timescale 1ns/1ps
`include "sse_params.svh"
module sse_exec #(
   parameter bit HAS_DCACHE = 1'b1
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_valid,
   input wire logic [31:0] i_instr,
   input wire logic [31:0] i_first_source_reg,
   input wire logic [31:0] i_second_source_reg,
   output sse_pkg::sse_store_t o_cache_store,
   output sse_pkg::sse_store_t o_bus_store,
   output sse_pkg::sse_wb_t o_wb,
   output logic o_sub_overflow,
   output logic o_sub_borrow,
   output logic o_illegal
);
   sse_pkg::sse_state_t state_r;
   sse_pkg::sse_state_t state_nxt;

   function automatic logic [3:0] lane_mask(input sse_pkg::sse_size_t sz,
                                            input logic [1:0] a);
      logic [3:0] m;
      m = 4'h0;
      case (sz)
         sse_pkg::SSE_SZ_BYTE: m = 4'h1 << a;
         sse_pkg::SSE_SZ_HALF: m = a[1] ? 4'hc : 4'h3;
         default: m = 4'hf;
      endcase
      return m;
   endfunction

   // srli and sub share the r-type opcode and differ only in the extension field
   function automatic logic rtype_op(input logic [5:0] op, input logic [5:0] ext,
                                     input logic [5:0] code);
      return op == `SSE_OP_RTYPE && ext == code;
   endfunction

   logic [5:0] opcode;
   logic [5:0] opx;
   logic [4:0] shift_amount_field;
   logic [15:0] offset_field;
   logic [31:0] eff_addr;
   logic [32:0] diff;
   logic is_store;
   logic is_io;
   logic is_srli;
   logic is_sub;
   sse_pkg::sse_size_t st_size;
   sse_pkg::sse_store_t st;

   assign opcode = i_instr[`SSE_OP_LSB +: `SSE_OP_W];
   assign opx = i_instr[`SSE_OPX_LSB +: `SSE_OPX_W];
   assign shift_amount_field = i_instr[`SSE_SHAMT_LSB +: `SSE_SHAMT_W];
   assign offset_field = i_instr[`SSE_OFFSET_LSB +: `SSE_OFFSET_W];
   // wraps naturally at 32 bits
   assign eff_addr = i_first_source_reg + {{16{offset_field[15]}}, offset_field};
   assign diff = {1'b0, i_first_source_reg} - {1'b0, i_second_source_reg};
   assign is_srli = rtype_op(opcode, opx, `SSE_OPX_SRLI);
   assign is_sub = rtype_op(opcode, opx, `SSE_OPX_SUB);

   always_comb begin
      is_store = 1'b1;
      is_io = 1'b0;
      st_size = sse_pkg::SSE_SZ_WORD;
      case (opcode)
         `SSE_OP_STB: st_size = sse_pkg::SSE_SZ_BYTE;
         `SSE_OP_STBIO: begin
            st_size = sse_pkg::SSE_SZ_BYTE;
            is_io = 1'b1;
         end
         `SSE_OP_STH: st_size = sse_pkg::SSE_SZ_HALF;
         `SSE_OP_STHIO: begin
            st_size = sse_pkg::SSE_SZ_HALF;
            is_io = 1'b1;
         end
         `SSE_OP_STW: st_size = sse_pkg::SSE_SZ_WORD;
         `SSE_OP_STWIO: is_io = 1'b1;
         default: is_store = 1'b0;
      endcase
   end

   always_comb begin
      st = '0;
      st.valid = i_valid && is_store;
      st.size = st_size;
      st.addr = eff_addr;
      // misaligned half/word addresses are passed as-is; result undefined
      st.byte_en = lane_mask(st_size, eff_addr[1:0]);
      case (st_size)
         sse_pkg::SSE_SZ_BYTE: st.data = {4{i_second_source_reg[7:0]}};
         sse_pkg::SSE_SZ_HALF: st.data = {2{i_second_source_reg[15:0]}};
         default: st.data = i_second_source_reg;
      endcase
      st.bypass = is_io && HAS_DCACHE;
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.cache_st = '0;
      state_nxt.bus_st = '0;
      state_nxt.wb = '0;
      state_nxt.illegal = 1'b0;
      if (i_valid) begin
         if (is_store) begin
            // without a cache every store goes straight to the bus
            if (HAS_DCACHE && !is_io) begin
               state_nxt.cache_st = st;
            end else begin
               state_nxt.bus_st = st;
            end
         end else if (is_srli) begin
            state_nxt.wb.valid = 1'b1;
            state_nxt.wb.dest = i_instr[`SSE_DEST_LSB +: 5];
            state_nxt.wb.value = i_first_source_reg >> shift_amount_field;
         end else if (is_sub) begin
            state_nxt.wb.valid = 1'b1;
            state_nxt.wb.dest = i_instr[`SSE_DEST_LSB +: 5];
            state_nxt.wb.value = diff[31:0];
            // informative only: both flags are held in state_r until the next subtract and raise no trap
            state_nxt.borrow = diff[32];
            state_nxt.ovf = (i_first_source_reg[31] ^ i_second_source_reg[31])
                            & (diff[31] ^ i_first_source_reg[31]);
         end else begin
            state_nxt.illegal = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign o_cache_store = state_r.cache_st;
   assign o_bus_store = state_r.bus_st;
   assign o_wb = state_r.wb;
   assign o_sub_overflow = state_r.ovf;
   assign o_sub_borrow = state_r.borrow;
   assign o_illegal = state_r.illegal;

   // each pulse is held against the inputs taken one edge earlier
   srl_shift_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_srli |=>
      o_wb.valid && o_wb.value == ($past(i_first_source_reg) >> $past(shift_amount_field)))
      else $error("srli result wrong");

   srl_fill_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_srli |=>
      (o_wb.value & ~(32'hffff_ffff >> $past(shift_amount_field))) == 32'h0000_0000)
      else $error("srli high bits not zero");

   wb_dest_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (is_srli || is_sub) |=>
      o_wb.valid && o_wb.dest == $past(i_instr[`SSE_DEST_LSB +: 5]))
      else $error("writeback destination wrong");

   shamt_range_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_srli && shift_amount_field == 5'd31
      |=> o_wb.value[31:1] == 31'h0)
      else $error("shift by 31 leaves high bits");

   shamt_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_srli && shift_amount_field == 5'd0
      |=> o_wb.value == $past(i_first_source_reg))
      else $error("shift by 0 changed value");

   store_addr_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_store |=> (o_cache_store.valid || o_bus_store.valid) &&
      (o_cache_store.addr | o_bus_store.addr) ==
      $past(i_first_source_reg) + {{16{$past(offset_field[15])}}, $past(offset_field)})
      else $error("store address wrong");

   byte_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (opcode == `SSE_OP_STB || opcode == `SSE_OP_STBIO) |=>
      $onehot(o_cache_store.byte_en | o_bus_store.byte_en) &&
      (o_cache_store.data[7:0] | o_bus_store.data[7:0]) == $past(i_second_source_reg[7:0]))
      else $error("byte store wrong");

   // only the low two address bits pick the lane, so the sum stays two bits wide
   byte_lane_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (opcode == `SSE_OP_STB || opcode == `SSE_OP_STBIO) |=>
      (o_cache_store.byte_en | o_bus_store.byte_en) ==
      4'h1 << ($past(i_first_source_reg[1:0]) + $past(offset_field[1:0])))
      else $error("byte lane wrong");

   half_data_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (opcode == `SSE_OP_STH || opcode == `SSE_OP_STHIO) |=>
      (o_cache_store.data[15:0] | o_bus_store.data[15:0]) == $past(i_second_source_reg[15:0]))
      else $error("half store wrong");

   half_lane_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (opcode == `SSE_OP_STH || opcode == `SSE_OP_STHIO) |=>
      (o_cache_store.byte_en | o_bus_store.byte_en) inside {4'h3, 4'hc})
      else $error("half lanes wrong");

   word_store_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && opcode == `SSE_OP_STW |=> o_cache_store.valid == HAS_DCACHE &&
      (o_cache_store.data | o_bus_store.data) == $past(i_second_source_reg))
      else $error("word store wrong");

   stwio_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && opcode == `SSE_OP_STWIO |=> o_bus_store.valid &&
      o_bus_store.size == sse_pkg::SSE_SZ_WORD && o_bus_store.byte_en == 4'hf &&
      o_bus_store.data == $past(i_second_source_reg))
      else $error("word io store wrong");

   io_bypass_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_store && is_io |=> o_bus_store.valid && !o_cache_store.valid)
      else $error("io store missed bus");

   io_flag_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_bus_store.valid |-> o_bus_store.bypass == HAS_DCACHE)
      else $error("bypass marking wrong");

   ord_cache_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_store && !is_io |=>
      o_cache_store.valid == HAS_DCACHE && o_bus_store.valid != HAS_DCACHE)
      else $error("ordinary store misrouted");

   no_cache_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !HAS_DCACHE |-> !o_cache_store.valid)
      else $error("cache store without a cache");

   stb_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && opcode == `SSE_OP_STB |=> o_cache_store.valid == HAS_DCACHE &&
      (o_cache_store.size | o_bus_store.size) == sse_pkg::SSE_SZ_BYTE)
      else $error("byte store opcode misdecoded");

   stbio_decode_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && opcode == `SSE_OP_STBIO |=>
      o_bus_store.valid && o_bus_store.size == sse_pkg::SSE_SZ_BYTE)
      else $error("byte io opcode misdecoded");

   sub_result_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_sub |=>
      o_wb.value == $past(i_first_source_reg) - $past(i_second_source_reg) &&
      o_sub_borrow == ($past(i_first_source_reg) < $past(i_second_source_reg)))
      else $error("sub result or borrow wrong");

   sub_ovf_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_sub |=> !o_illegal && o_sub_overflow ==
      (($past(i_first_source_reg[31]) != $past(i_second_source_reg[31])) &&
      (o_wb.value[31] != $past(i_first_source_reg[31]))))
      else $error("overflow flag wrong or trapped");

   // adding the subtrahend back must restore the minuend at 32 bits
   sub_wrap_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && is_sub |=>
      o_wb.value + $past(i_second_source_reg) == $past(i_first_source_reg))
      else $error("subtract does not wrap");

   no_side_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_wb.valid |-> !o_cache_store.valid && !o_bus_store.valid)
      else $error("alu op touched memory");

   alu_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && (is_srli || is_sub) |=>
      !o_cache_store.valid && !o_bus_store.valid && !o_illegal)
      else $error("alu op raised another output");

   // flags are informative and only a subtract may move them
   flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !(i_valid && is_sub) |=> $stable(o_sub_overflow) && $stable(o_sub_borrow))
      else $error("flags moved without a subtract");

   illegal_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_valid && !is_store && !is_srli && !is_sub |=> o_illegal && !o_wb.valid)
      else $error("unknown instruction not flagged");

   idle_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_valid |=> !o_cache_store.valid && !o_bus_store.valid && !o_wb.valid && !o_illegal)
      else $error("output without an instruction");

   one_result_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $onehot0({o_cache_store.valid, o_bus_store.valid, o_wb.valid, o_illegal}))
      else $error("more than one result");

   // main scenarios that the stimulus is expected to reach
   ovf_cov_c: cover property (@(posedge i_clk_sys) o_wb.valid && o_sub_overflow);
   io_cov_c: cover property (@(posedge i_clk_sys) o_bus_store.valid && o_bus_store.bypass);
   cache_cov_c: cover property (@(posedge i_clk_sys) o_cache_store.valid);
   borrow_cov_c: cover property (@(posedge i_clk_sys) o_wb.valid && o_sub_borrow);
   shift31_cov_c: cover property (@(posedge i_clk_sys)
      i_valid && is_srli && shift_amount_field == 5'd31);
endmodule

// ==== verification/sse_mem_model.sv ====
// far-side sink standing for the data cache and the system bus
`timescale 1ns/1ps
module sse_mem_model (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input sse_pkg::sse_store_t i_cache_store,
   input sse_pkg::sse_store_t i_bus_store,
   output int o_bus_count,
   output int o_cache_count
);
   // no back-pressure exists, so the sink only counts what arrives
   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_bus_count <= 0;
         o_cache_count <= 0;
      end else begin
         if (i_bus_store.valid === 1'b1) o_bus_count <= o_bus_count + 1;
         if (i_cache_store.valid === 1'b1) o_cache_count <= o_cache_count + 1;
      end
   end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the shift, store and subtract unit
`timescale 1ns/1ps
`include "sse_params.svh"
module testbench;
   logic i_clk_sys = 0, i_rst = 1, i_valid = 0;
   logic [31:0] i_instr = 0, a = 0, b = 0;
   sse_pkg::sse_store_t cst, bst;
   sse_pkg::sse_wb_t wb;
   logic ovf, bor, ill;
   sse_pkg::sse_store_t ncst, nbst, nx;
   sse_pkg::sse_wb_t nwb;
   logic novf, nbor, nill;
   int bus_n, cache_n, fail_count = 0, checked = 0, io_n = 0, st_n = 0;
   sse_pkg::sse_state_t q[$], e;
   always #50 i_clk_sys = ~i_clk_sys;
   sse_exec dut (.i_clk_sys, .i_rst, .i_valid, .i_instr, .i_first_source_reg(a),
      .i_second_source_reg(b), .o_cache_store(cst), .o_bus_store(bst), .o_wb(wb),
      .o_sub_overflow(ovf), .o_sub_borrow(bor), .o_illegal(ill));
   sse_mem_model far (.i_clk_sys, .i_rst, .i_cache_store(cst), .i_bus_store(bst),
      .o_bus_count(bus_n), .o_cache_count(cache_n));
   // second unit built without a data cache, fed the same stream
   sse_exec #(.HAS_DCACHE(1'b0)) dut_nc (.i_clk_sys, .i_rst, .i_valid, .i_instr,
      .i_first_source_reg(a), .i_second_source_reg(b), .o_cache_store(ncst),
      .o_bus_store(nbst), .o_wb(nwb), .o_sub_overflow(novf), .o_sub_borrow(nbor),
      .o_illegal(nill));
   task automatic fail(input string m);
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic cmp_st(input sse_pkg::sse_store_t g, x, input string m);
      checked++;
      if (g.valid !== x.valid || (x.valid && g !== x)) fail(m);
   endtask
   task automatic cmp_wb(input sse_pkg::sse_wb_t g, x);
      checked++;
      if (g.valid !== x.valid || (x.valid && g !== x)) fail("writeback");
   endtask
   task automatic cmp_bit(input logic g, x, input string m);
      checked++;
      if (g !== x) fail(m);
   endtask
   task automatic close_out();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(negedge i_clk_sys) begin
      if (!i_rst && (cst.valid || bst.valid || wb.valid || ill)) begin
         if (q.size() == 0) begin
            fail("unexpected output");
         end else begin
            e = q.pop_front();
            cmp_st(cst, e.cache_st, "cache store");
            cmp_st(bst, e.bus_st, "bus store");
            cmp_wb(wb, e.wb);
            cmp_bit(ovf, e.ovf, "overflow");
            cmp_bit(bor, e.borrow, "borrow");
            cmp_bit(ill, e.illegal, "illegal");
            // without a cache every store lands on the bus, unmarked
            nx = e.cache_st | e.bus_st;
            nx.bypass = 1'b0;
            cmp_st(ncst, '0, "nc cache store");
            cmp_st(nbst, nx, "nc bus store");
            cmp_wb(nwb, e.wb);
            cmp_bit(novf, e.ovf, "nc overflow");
            cmp_bit(nbor, e.borrow, "nc borrow");
            cmp_bit(nill, e.illegal, "nc illegal");
         end
      end
   end
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      fail("watchdog");
      close_out();
   end
   initial begin
      logic [5:0] ops [6];
      logic [4:0] sh, r1, r2;
      logic [15:0] off;
      logic [31:0] x, y, ad, d;
      logic h_ovf, h_bor;
      sse_pkg::sse_state_t ex;
      sse_pkg::sse_store_t s;
      int k;
      ops = '{`SSE_OP_STB, `SSE_OP_STBIO, `SSE_OP_STH, `SSE_OP_STHIO, `SSE_OP_STW, `SSE_OP_STWIO};
      h_ovf = 0;
      h_bor = 0;
      x = $urandom(34055);
      repeat (16) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int n = 0; n < 400; n++) begin
         k = (n < 20) ? n % 10 : $urandom_range(9);
         x = $urandom;
         y = (n % 7 == 0) ? x ^ 32'h8000_0000 : $urandom;
         sh = (n < 20) ? {5{n[4]}} : 5'($urandom);
         off = $urandom;
         r1 = $urandom;
         r2 = $urandom;
         ex = '0;
         if (k < 6) begin
            ad = x + {{16{off[15]}}, off};
            // keep half and word stores aligned, misalignment is undefined
            x = x - (ad & ((k < 2) ? 0 : (k < 4) ? 1 : 3));
            ad = x + {{16{off[15]}}, off};
            s.valid = 1'b1;
            s.bypass = k[0];
            s.size = sse_pkg::sse_size_t'(k / 2);
            s.addr = ad;
            s.data = (k < 2) ? {4{y[7:0]}} : (k < 4) ? {2{y[15:0]}} : y;
            s.byte_en = (k < 2) ? 4'b0001 << ad[1:0] : (k < 4) ? (ad[1] ? 4'b1100 : 4'b0011)
               : 4'b1111;
            if (k[0]) ex.bus_st = s;
            else ex.cache_st = s;
            io_n += k % 2;
            st_n += 1 - k % 2;
            i_instr <= {r1, r2, off, ops[k]};
         end else if (k == 6) begin
            ex.wb = '{1'b1, r2, x >> sh};
            i_instr <= {r1, 5'd0, r2, 6'(`SSE_OPX_SRLI), sh, 6'(`SSE_OP_RTYPE)};
         end else if (k < 9) begin
            d = x - y;
            h_bor = x < y;
            h_ovf = (x[31] != y[31]) && (d[31] != x[31]);
            ex.wb = '{1'b1, r2, d};
            i_instr <= {r1, sh, r2, 6'(`SSE_OPX_SUB), 5'd0, 6'(`SSE_OP_RTYPE)};
         end else begin
            ex.illegal = 1'b1;
            i_instr <= {r1, r2, off, 6'h3f};
         end
         ex.ovf = h_ovf;
         ex.borrow = h_bor;
         i_valid <= 1'b1;
         a <= x;
         b <= y;
         q.push_back(ex);
         @(posedge i_clk_sys);
         if ($urandom_range(3) == 0) begin
            i_valid <= 1'b0;
            @(posedge i_clk_sys);
         end
      end
      i_valid <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      cmp_bit(q.size() == 0, 1'b1, "missing output");
      cmp_bit(bus_n == io_n, 1'b1, "bus count");
      cmp_bit(cache_n == st_n, 1'b1, "cache count");
      close_out();
   end
endmodule
